/* File: hdl/gcs_regs.vh */
`ifndef GCS_REGS_VH
`define GCS_REGS_VH

// internal i/o addresses
`define GCS_ADDR_CTRL        8'h00
`define GCS_ADDR_CPU_ID      8'h2E
`define GCS_ADDR_REV_ID      8'h2F

// control/status field positions
`define GCS_STAT_HI          7
`define GCS_STAT_LO          6
`define GCS_FORCE_BIT        5
`define GCS_SEL_HI           4
`define GCS_SEL_LO           2
`define GCS_PRIO_HI          1
`define GCS_PRIO_LO          0

// cause codes in bits 7:6
`define GCS_CAUSE_NONE       2'h0
`define GCS_CAUSE_WDOG       2'h1
`define GCS_CAUSE_RESET      2'h3

// clock select reset value and codes
`define GCS_SEL_RESET        3'h0
`define GCS_SEL_BOTH_DIV8    3'h0
`define GCS_SEL_CPU_DIV8     3'h1
`define GCS_SEL_UNDIV_A      3'h2
`define GCS_SEL_UNDIV_B      3'h3
`define GCS_SEL_SLOW_A       3'h4
`define GCS_SEL_SLOW_OFF_A   3'h5
`define GCS_SEL_SLOW_B       3'h6
`define GCS_SEL_SLOW_OFF_B   3'h7

// periodic interrupt priority
`define GCS_PRIO_RESET       2'h0
`define GCS_PRIO_OFF         2'h0

// main path divider: 3 bits gives divide by eight
`define GCS_DIV8_W           3
`define GCS_DIV8_LAST        3'h7

// periodic request every 16 slow oscillator periods
`define GCS_PER_W            4
`define GCS_PER_LAST         4'hF

// identity fields
`define GCS_ID_W             5
`define GCS_BYTE_ZERO        8'h00

`endif

/* File: hdl/gcs_top.v */
`include "gcs_regs.vh"

module gcs_top #(
  parameter [4:0] CPU_ID = 5'h0A,  // arbitrary value
  parameter [4:0] REV_ID = 5'h01   // arbitrary value
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // oscillator pins
  input  wire       osc_main,
  input  wire       osc_slow,
  // internal i/o register port
  input  wire [7:0] io_addr,
  input  wire       io_rd,
  input  wire       io_wr,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  // event from the watchdog
  input  wire       wdog_timeout,
  // clock path controls
  input  wire       doubler_enable,
  input  wire       clk_pin_enable,
  input  wire       clk_pin_halve,
  input  wire       clk_pin_gpo,
  // clock outputs
  output reg        cpu_tick,
  output reg        periph_tick,
  output reg        slow_tick,
  output reg        main_osc_enable,
  output reg        clk_pin,
  // periodic interrupt
  output reg        periodic_req,
  output reg  [1:0] periodic_prio
);

  // oscillator pin synchronisers
  wire [1:0] osc_pin;
  reg  [1:0] osc_meta;
  reg  [1:0] osc_sync;
  reg  [1:0] osc_prev;

  assign osc_pin = {osc_slow, osc_main};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sync
      always @(posedge clk) begin
        if (!rst_n) begin
          osc_meta[i] <= 1'b0;
          osc_sync[i] <= 1'b0;
          osc_prev[i] <= 1'b0;
        end else begin
          osc_meta[i] <= osc_pin[i];
          osc_sync[i] <= osc_meta[i];
          osc_prev[i] <= osc_sync[i];
        end
      end
    end
  endgenerate

  wire main_rise = osc_sync[0] & ~osc_prev[0];
  wire main_any  = osc_sync[0] ^ osc_prev[0];
  wire slow_rise = osc_sync[1] & ~osc_prev[1];

  // control state
  reg [1:0] cause;
  reg [2:0] clk_sel;
  reg       pending;

  // register port decode
  wire ctrl_hit = (io_addr == `GCS_ADDR_CTRL);
  wire ctrl_rd  = io_rd & ctrl_hit;
  wire ctrl_wr  = io_wr & ctrl_hit;

  // clock select decode, one row per select code
  reg sel_slow;
  reg sel_off;
  reg cpu_div;
  reg per_div;

  always @* begin
    sel_slow = 1'b0;
    sel_off  = 1'b0;
    cpu_div  = 1'b0;
    per_div  = 1'b0;
    case (clk_sel)
      `GCS_SEL_BOTH_DIV8: begin
        cpu_div = 1'b1;
        per_div = 1'b1;
      end
      `GCS_SEL_CPU_DIV8: begin
        cpu_div = 1'b1;
      end
      `GCS_SEL_UNDIV_A: begin
        cpu_div = 1'b0;
      end
      `GCS_SEL_UNDIV_B: begin
        cpu_div = 1'b0;
      end
      `GCS_SEL_SLOW_A: begin
        sel_slow = 1'b1;
      end
      `GCS_SEL_SLOW_OFF_A: begin
        sel_slow = 1'b1;
        sel_off  = 1'b1;
      end
      `GCS_SEL_SLOW_B: begin
        sel_slow = 1'b1;
      end
      `GCS_SEL_SLOW_OFF_B: begin
        sel_slow = 1'b1;
        sel_off  = 1'b1;
      end
      default: begin
        sel_slow = 1'b0;
      end
    endcase
  end

  // main oscillator path
  reg  [2:0] div8_cnt;
  wire       main_edge;
  wire       div8_tick;

  // a stopped oscillator must not leak edges from a stale pin
  assign main_edge = main_osc_enable &
                     (doubler_enable ? main_any : main_rise);
  assign div8_tick = main_edge & (div8_cnt == `GCS_DIV8_LAST);

  always @(posedge clk) begin
    if (!rst_n) begin
      div8_cnt <= {`GCS_DIV8_W{1'b0}};
    end else if (!main_osc_enable) begin
      // a restarted main oscillator begins a full divide period
      div8_cnt <= {`GCS_DIV8_W{1'b0}};
    end else if (main_edge) begin
      div8_cnt <= div8_cnt + 3'h1;
    end
  end

  // processor and peripheral clock selection
  reg next_cpu_tick;
  reg next_periph_tick;

  always @* begin
    if (sel_slow) begin
      next_cpu_tick    = slow_rise;
      next_periph_tick = slow_rise;
    end else begin
      next_cpu_tick    = cpu_div ? div8_tick : main_edge;
      next_periph_tick = per_div ? div8_tick : main_edge;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cpu_tick <= 1'b0;
    end else begin
      cpu_tick <= next_cpu_tick;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      periph_tick <= 1'b0;
    end else begin
      periph_tick <= next_periph_tick;
    end
  end

  // watchdog and time counter keep their clock whatever the select
  always @(posedge clk) begin
    if (!rst_n) begin
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= slow_rise;
    end
  end

  // registered so a select write cannot chop the oscillator enable
  always @(posedge clk) begin
    if (!rst_n) begin
      main_osc_enable <= 1'b1;
    end else begin
      main_osc_enable <= ~sel_off;
    end
  end

  // clock pin: levels advance only on processor ticks
  reg cpu_level;
  reg half_level;
  reg next_clk_pin;

  always @(posedge clk) begin
    if (!rst_n) begin
      cpu_level <= 1'b0;
    end else if (cpu_tick) begin
      cpu_level <= ~cpu_level;
    end
  end

  // halving on the rising level keeps the pin edges on processor ticks
  always @(posedge clk) begin
    if (!rst_n) begin
      half_level <= 1'b0;
    end else if (cpu_tick & ~cpu_level) begin
      half_level <= ~half_level;
    end
  end

  always @* begin
    if (!clk_pin_enable) begin
      next_clk_pin = clk_pin_gpo;
    end else if (clk_pin_halve) begin
      next_clk_pin = half_level;
    end else begin
      next_clk_pin = cpu_level;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      clk_pin <= 1'b0;
    end else begin
      clk_pin <= next_clk_pin;
    end
  end

  // periodic interrupt timebase from the slow oscillator
  reg  [3:0] per_cnt;
  wire       per_event = slow_rise & (per_cnt == `GCS_PER_LAST);

  always @(posedge clk) begin
    if (!rst_n) begin
      per_cnt <= {`GCS_PER_W{1'b0}};
    end else if (slow_rise) begin
      per_cnt <= per_cnt + 4'h1;
    end
  end

  // control register writes
  wire [1:0] next_prio = ctrl_wr ? io_wdata[`GCS_PRIO_HI:`GCS_PRIO_LO] : periodic_prio;

  always @(posedge clk) begin
    if (!rst_n) begin
      clk_sel       <= `GCS_SEL_RESET;
      periodic_prio <= `GCS_PRIO_RESET;
    end else begin
      periodic_prio <= next_prio;
      if (ctrl_wr) begin
        clk_sel <= io_wdata[`GCS_SEL_HI:`GCS_SEL_LO];
      end
    end
  end

  // pending request: a new event beats a clearing read
  wire force_hit    = ctrl_wr & io_wdata[`GCS_FORCE_BIT];
  wire req_set      = per_event | force_hit;
  wire next_pending = req_set | (pending & ~ctrl_rd);

  always @(posedge clk) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  // request and priority move on one edge, so a disabled priority never shows a request
  always @(posedge clk) begin
    if (!rst_n) begin
      periodic_req <= 1'b0;
    end else begin
      periodic_req <= next_pending & (next_prio != `GCS_PRIO_OFF);
    end
  end

  // cause bits: reset loads 11, watchdog 01, read clears
  reg [1:0] next_cause;

  always @* begin
    next_cause = cause;
    if (ctrl_rd) begin
      next_cause = `GCS_CAUSE_NONE;
    end
    if (wdog_timeout) begin
      // an unread reset cause stays 11 so 10 can never form
      if (ctrl_rd || cause != `GCS_CAUSE_RESET) begin
        next_cause = `GCS_CAUSE_WDOG;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cause <= `GCS_CAUSE_RESET;
    end else begin
      cause <= next_cause;
    end
  end

  // read data
  reg [7:0] next_rdata;

  always @* begin
    case (io_addr)
      `GCS_ADDR_CTRL: begin
        // write-only fields and bit 5 read as zero
        next_rdata = {cause, 6'h00};
      end
      `GCS_ADDR_CPU_ID: begin
        next_rdata = {3'h0, CPU_ID};
      end
      `GCS_ADDR_REV_ID: begin
        next_rdata = {3'h0, REV_ID};
      end
      default: begin
        next_rdata = `GCS_BYTE_ZERO;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      io_rdata <= `GCS_BYTE_ZERO;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

endmodule

/* File: tb/gcs_top_sva.sv */
module gcs_chk #(
  parameter [4:0] CPU_ID = 5'h0A,
  parameter [4:0] REV_ID = 5'h01
) (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // register port
  input wire [7:0] io_addr,
  input wire       io_rd,
  input wire       io_wr,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire       wdog_timeout,
  // status outputs
  input wire       main_osc_enable,
  input wire       periodic_req,
  input wire [1:0] periodic_prio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen_rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd0; io_rd && io_addr == 8'h00; endsequence
  sequence s_wr0; io_wr && io_addr == 8'h00; endsequence
  sequence s_quiet_rd; !wdog_timeout ##1 s_rd0; endsequence
  // first control read after reset must report the reset cause
  always @(posedge clk) begin
    if (!rst_n)
      seen_rd <= 1'b0;
    else if (io_rd && io_addr == 8'h00)
      seen_rd <= 1'b1;
  end
  low_bits_zero_a: assert property (s_rd0 |=> io_rdata[5:0] == 6'h00)
    else $error("control low bits not zero");
  no_cause_ten_a: assert property (s_rd0 |=> io_rdata[7:6] != 2'h2)
    else $error("cause reads 10");
  reset_cause_a: assert property (s_rd0 ##0 !seen_rd |=> io_rdata[7:6] == 2'h3)
    else $error("reset cause missing");
  cause_cleared_a: assert property ((s_rd0 ##0 !wdog_timeout) ##1 s_quiet_rd |=> io_rdata[7:6] == 2'h0)
    else $error("cause not cleared");
  wdog_cause_a: assert property ((s_rd0 ##0 wdog_timeout) ##1 s_quiet_rd |=> io_rdata[7:6] == 2'h1)
    else $error("watchdog cause missing");
  force_req_a: assert property (s_wr0 ##0 (io_wdata[5] && io_wdata[1:0] != 2'h0) |=> periodic_req)
    else $error("forced request missing");
  prio_follow_a: assert property (s_wr0 |=> periodic_prio == $past(io_wdata[1:0]))
    else $error("priority not taken");
  prio_off_a: assert property (periodic_prio == 2'h0 |-> !periodic_req)
    else $error("request with priority off");
  main_off_a: assert property (s_wr0 ##0 (io_wdata[4] && io_wdata[2]) |-> ##[1:2] !main_osc_enable)
    else $error("main oscillator not stopped");
  cpu_id_a: assert property (io_rd && io_addr == 8'h2E |=> io_rdata[4:0] == CPU_ID)
    else $error("cpu identity wrong");
  rev_id_a: assert property (io_rd && io_addr == 8'h2F |=> io_rdata[4:0] == REV_ID)
    else $error("revision identity wrong");
endmodule

bind gcs_top gcs_chk #(.CPU_ID(CPU_ID), .REV_ID(REV_ID)) chk_u (.clk, .rst_n, .io_addr, .io_rd, .io_wr,
  .io_wdata, .io_rdata, .wdog_timeout, .main_osc_enable, .periodic_req, .periodic_prio);

/* File: tb/gcs_top_tb.sv */
module gcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, osc_main = 0, osc_slow = 0, io_rd = 0, io_wr = 0, wdog_timeout = 0;
  logic       doubler_enable = 0, clk_pin_enable = 0, clk_pin_halve = 0, clk_pin_gpo = 0, slow_run = 0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, d;
  wire  [7:0] io_rdata;
  wire  [1:0] periodic_prio;
  wire        cpu_tick, periph_tick, slow_tick, main_osc_enable, clk_pin, periodic_req;
  int         fail_count = 0, checks = 0, n;
  gcs_top #(.CPU_ID(5'h15), .REV_ID(5'h06)) dut_u (.clk, .rst_n, .osc_main, .osc_slow, .io_addr, .io_rd,
    .io_wr, .io_wdata, .io_rdata, .wdog_timeout, .doubler_enable, .clk_pin_enable, .clk_pin_halve,
    .clk_pin_gpo, .cpu_tick, .periph_tick, .slow_tick, .main_osc_enable, .clk_pin, .periodic_req, .periodic_prio);
  always #50 clk = ~clk;
  // both oscillators change on falling clock edges, slow one only when enabled
  always #200 osc_main = ~osc_main;
  always #800 if (slow_run) osc_slow = ~osc_slow;
  task chk(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // tick counts tolerate window edges against free-running dividers
  task rng(input int g, e);
    checks++;
    if (g < e - 2 || g > e + 2) begin
      fail_count++;
      $display("Error at %0t: count %0d expected %0d", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, v);
    @(negedge clk);
    io_addr = a;
    io_wdata = v;
    io_wr = 1;
    @(negedge clk);
    io_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk);
    io_addr = a;
    io_rd = 1;
    @(negedge clk);
    io_rd = 0;
    d = io_rdata;
  endtask
  // bounded wait for the periodic request, counting falling edges
  task automatic wait_req(output int cnt);
    cnt = 0;
    while (!periodic_req && cnt < 300) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic meas(input logic [7:0] sel, input int c, p, k);
    int   nc = 0, np = 0, ns = 0, nk = 0;
    logic last;
    wr(8'h00, sel);
    repeat (8) @(negedge clk);
    last = clk_pin;
    repeat (512) @(negedge clk) begin
      nc += cpu_tick;
      np += periph_tick;
      ns += slow_tick;
      nk += (clk_pin != last);
      last = clk_pin;
    end
    rng(nc, c);
    rng(np, p);
    rng(ns, 32);
    rng(nk, k);
  endtask
  task wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    rd(8'h00);
    chk(d, 8'hC0);
    rd(8'h00);
    chk(d, 8'h00);
    wdog_timeout = 1;
    rd(8'h00);
    wdog_timeout = 0;
    rd(8'h00);
    chk(d, 8'h40);
    rd(8'h00);
    chk(d, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'h20 | p[7:0]);
      chk({6'h00, periodic_prio}, p[7:0]);
      chk({7'h00, periodic_req}, {7'h00, p != 0});
      rd(8'h00);
      chk({7'h00, periodic_req}, 8'h00);
      chk(d, 8'h00);
    end
    rd(8'h2E);
    chk({3'h0, d[4:0]}, 8'h15);
    rd(8'h2F);
    chk({3'h0, d[4:0]}, 8'h06);
    wr(8'h55, 8'h14);
    rd(8'h55);
    chk(d, 8'h00);
    chk({7'h00, main_osc_enable}, 8'h01);
    clk_pin_gpo = 1;
    repeat (3) @(negedge clk);
    chk({7'h00, clk_pin}, 8'h01);
    clk_pin_enable = 1;
    slow_run = 1;
    meas(8'h00, 16, 16, 16);
    meas(8'h04, 16, 128, 16);
    meas(8'h0C, 128, 128, 128);
    clk_pin_halve = 1;
    meas(8'h08, 128, 128, 64);
    clk_pin_halve = 0;
    doubler_enable = 1;
    meas(8'h00, 32, 32, 32);
    doubler_enable = 0;
    meas(8'h18, 32, 32, 32);
    chk({7'h00, main_osc_enable}, 8'h01);
    meas(8'h14, 32, 32, 32);
    chk({7'h00, main_osc_enable}, 8'h00);
    // periodic timebase: 16 slow periods of 16 clocks, less the two cycles of the clearing read
    wr(8'h00, 8'h15);
    wait_req(n);
    rd(8'h00);
    wait_req(n);
    chk({7'h00, periodic_req}, 8'h01);
    rd(8'h00);
    chk({7'h00, periodic_req}, 8'h00);
    wait_req(n);
    rng(n, 254);
    chk({7'h00, periodic_req}, 8'h01);
    wrap_up();
  end
endmodule
